// [drs_pkg.sv]
/*
 Package for the dual rail sequence supervisor: register map, field positions,
 reset values, sequencer states and timing constants.
 Assumes a 25 MHz system clock and a single AHB-Lite slave port.
*/
`default_nettype none
package drs_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned RST_DELAY_MS   = 120;
   localparam int unsigned RST_DELAY_CYC  = (CLK_HZ / 1000) * RST_DELAY_MS;
   localparam int unsigned TICK_DIV       = 25;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQST  = 8'h08;
   localparam logic [7:0] OFF_IRQMSK = 8'h0C;

   // Control fields
   localparam int CTRL_OVR_EN  = 0;
   localparam int CTRL_RST_FRC = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Event fields (status and mask share this layout)
   localparam int EV_R1_ON   = 0;
   localparam int EV_R2_ON   = 1;
   localparam int EV_PG_UP   = 2;
   localparam int EV_PG_DN   = 3;
   localparam int EV_RST_REL = 4;
   localparam int EV_RST_ASS = 5;
   localparam int EV_W       = 6;
   localparam logic [5:0] MASK_RESET = 6'h00;

   typedef enum logic [3:0] {
      ST_OFF     = 4'h1,
      ST_FIRST   = 4'h2,
      ST_BOTH    = 4'h4,
      ST_SPARE   = 4'h8
   } drs_seq_t;
endpackage : drs_pkg
`default_nettype wire

// [drs_sync.sv]
/*
 Two flip-flop synchroniser for a bus of asynchronous level inputs.
 Assumes the inputs are slow levels; no pulse is shorter than two clocks.
*/
`default_nettype none
module drs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Levels
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } drs_sync_t;

   drs_sync_t s_q;
   drs_sync_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.meta = asyncIn;
      s_d.sync = s_q.meta;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '{meta: INIT, sync: INIT};
      end else begin
         s_q <= s_d;
      end
   end

   assign syncOut = s_q.sync;
endmodule : drs_sync
`default_nettype wire

// [drs_supervisor.sv]
/*
 Digital control of a dual output regulator: enable, power-up ordering,
 rail one good flag and supervisory reset with release delay, plus an
 AHB-Lite register slave with sticky event bits and one interrupt line.
 Assumes rail comparators and pins arrive asynchronously; pull-ups are modelled
 by treating an undriven input as high at the pad (bench drives 1 for open).
*/
// Functional notes
// - While the enable input is high both rails are held off.
// - Driving enable low starts the selected power-up order.
// - With order select high rail two starts first and rail one waits for the 83% mark.
// - In that order rail one is switched off when rail two drops below 83%.
// - With order select low rail one is switched on first.
// - Order select has a pull-up so an open input counts as high.
// - The rail one good flag is released once rail one is above 95%.
// - The rail one good flag is pulled low whenever rail one is below 95%.
// - Either manual reset input low asserts the reset output.
// - Both manual reset inputs are active low with pull-ups.
// - Reset releases 120 ms after rail two is good and both manual resets are high.
// - Reset is pulled low at once when rail two falls below 95%.
// - Level monitors trip 5% low with hysteresis, supplied here as comparator levels.
// - Both rails stay off until the first supply passes its lockout level.
// - A rail that is off has its discharge path switched on.
`default_nettype none
module drs_supervisor #(
   parameter int unsigned DELAY_CYC = drs_pkg::RST_DELAY_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Control pins
   input  wire logic        enableIn_n,
   input  wire logic        orderSelect,
   input  wire logic        manualResetA_n,
   input  wire logic        manualResetB_n,
   // Comparator levels
   input  wire logic        supplyOneOk,
   input  wire logic        railTwoAbove83,
   input  wire logic        railOneAbove95,
   input  wire logic        railTwoAbove95,
   // Regulator controls
   output logic             railOneOn,
   output logic             railTwoOn,
   output logic             railOneDischarge,
   output logic             railTwoDischarge,
   // Open-drain outputs
   output logic             goodFlagOut,
   output logic             goodFlagOe,
   output logic             resetOut,
   output logic             resetOe,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq
);
   localparam int CW = $clog2(DELAY_CYC + 1);

   initial begin
      if (DELAY_CYC < 2) begin
         $error("DELAY_CYC too small");
      end
   end

   typedef struct packed {
      drs_pkg::drs_seq_t seq;
      logic              r1On;
      logic              r2On;
      logic              r1Dis;
      logic              r2Dis;
      logic              pgLow;
      logic              rstLow;
      logic [CW-1:0]     cnt;
      logic [1:0]        ctrl;
      logic [5:0]        stat;
      logic [5:0]        mask;
      logic              dWr;
      logic              dRd;
      logic [7:0]        dAddr;
      logic [31:0]       rdata;
      logic              irq;
   } drs_state_t;

   drs_state_t s_q;
   drs_state_t s_d;

   logic [7:0] syncLv;
   logic       enN;
   logic       ordSel;
   logic       mrA;
   logic       mrB;
   logic       supOk;
   logic       r2At83;
   logic       r1At95;
   logic       r2At95;
   logic       rstAsk;
   logic [5:0] ev;

   // Pads synchronised; open pull-up inputs reset high
   drs_sync #(.W(8), .INIT(8'h0F)) uSync (
      .clk     (clk),
      .rst_n   (rst_n),
      .asyncIn ({railTwoAbove95, railOneAbove95, railTwoAbove83, supplyOneOk,
                 manualResetB_n, manualResetA_n, orderSelect, enableIn_n}),
      .syncOut (syncLv[7:0])
   );
   assign enN    = syncLv[0];
   assign ordSel = syncLv[1];
   assign mrA    = syncLv[2];
   assign mrB    = syncLv[3];
   assign supOk  = syncLv[4];
   assign r2At83 = syncLv[5];
   assign r1At95 = syncLv[6];
   assign r2At95 = syncLv[7];

   // Reset requested by any manual input, low rail two or software
   assign rstAsk = !mrA || !mrB || !r2At95 || s_q.ctrl[drs_pkg::CTRL_RST_FRC];

   always_comb begin
      s_d = s_q;
      ev  = '0;
      // Sequencer
      if (enN || !supOk || s_q.ctrl[drs_pkg::CTRL_OVR_EN]) begin
         s_d.seq  = drs_pkg::ST_OFF;
         s_d.r1On = 1'b0;
         s_d.r2On = 1'b0;
      end else begin
         unique case (s_q.seq)
            drs_pkg::ST_OFF: begin
               s_d.seq = drs_pkg::ST_FIRST;
               if (ordSel) begin
                  s_d.r2On = 1'b1;
               end else begin
                  s_d.r1On = 1'b1;
               end
            end
            drs_pkg::ST_FIRST: begin
               s_d.seq  = drs_pkg::ST_BOTH;
               s_d.r1On = 1'b1;
               s_d.r2On = 1'b1;
               if (ordSel && !r2At83) begin
                  s_d.seq  = drs_pkg::ST_FIRST;
                  s_d.r1On = 1'b0;
               end
            end
            drs_pkg::ST_BOTH: begin
               if (ordSel && !r2At83) begin
                  s_d.seq  = drs_pkg::ST_FIRST;
                  s_d.r1On = 1'b0;
               end
            end
            default: begin
               s_d.seq  = drs_pkg::ST_OFF;
               s_d.r1On = 1'b0;
               s_d.r2On = 1'b0;
            end
         endcase
      end
      // Discharge paths registered so the pins come straight from flops
      s_d.r1Dis = !s_d.r1On;
      s_d.r2Dis = !s_d.r2On;
      // Good flag follows the synchronised comparator
      s_d.pgLow = !r1At95;
      // Reset output and release delay
      if (rstAsk) begin
         s_d.rstLow = 1'b1;
         s_d.cnt    = '0;
      end else if (s_q.rstLow) begin
         if (s_q.cnt == CW'(DELAY_CYC - 1)) begin
            s_d.rstLow = 1'b0;
         end else begin
            s_d.cnt = s_q.cnt + 1'b1;
         end
      end
      // Events
      ev[drs_pkg::EV_R1_ON]   = s_d.r1On && !s_q.r1On;
      ev[drs_pkg::EV_R2_ON]   = s_d.r2On && !s_q.r2On;
      ev[drs_pkg::EV_PG_UP]   = !s_d.pgLow && s_q.pgLow;
      ev[drs_pkg::EV_PG_DN]   = s_d.pgLow && !s_q.pgLow;
      ev[drs_pkg::EV_RST_REL] = !s_d.rstLow && s_q.rstLow;
      ev[drs_pkg::EV_RST_ASS] = s_d.rstLow && !s_q.rstLow;
      // Bus data phase: writes land, set beats clear
      if (s_q.dWr) begin
         unique case (s_q.dAddr)
            drs_pkg::OFF_CTRL:   s_d.ctrl = hwdata[1:0];
            drs_pkg::OFF_IRQST:  s_d.stat = s_q.stat & ~hwdata[5:0];
            drs_pkg::OFF_IRQMSK: s_d.mask = hwdata[5:0];
            default: ;
         endcase
      end
      s_d.stat = s_d.stat | ev;
      // Bus address phase
      s_d.dWr   = hsel && hready && htrans[1] && hwrite;
      s_d.dRd   = hsel && hready && htrans[1] && !hwrite;
      s_d.dAddr = haddr[7:0];
      s_d.rdata = '0;
      if (hsel && hready && htrans[1] && !hwrite) begin
         unique case (haddr[7:0])
            drs_pkg::OFF_CTRL:   s_d.rdata = {30'h0, s_q.ctrl};
            drs_pkg::OFF_STATUS: s_d.rdata = {22'h0, s_q.seq, ordSel, s_q.rstLow,
                                              s_q.pgLow, s_q.r2On, s_q.r1On, enN};
            drs_pkg::OFF_IRQST:  s_d.rdata = {26'h0, s_q.stat};
            drs_pkg::OFF_IRQMSK: s_d.rdata = {26'h0, s_q.mask};
            default:             s_d.rdata = 32'h0;
         endcase
      end
      s_d.irq = |(s_d.stat & s_d.mask);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q        <= '0;
         s_q.seq    <= drs_pkg::ST_OFF;
         s_q.r1Dis  <= 1'b1;
         s_q.r2Dis  <= 1'b1;
         s_q.pgLow  <= 1'b1;
         s_q.rstLow <= 1'b1;
         s_q.ctrl   <= drs_pkg::CTRL_RESET;
         s_q.mask   <= drs_pkg::MASK_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign railOneOn        = s_q.r1On;
   assign railTwoOn        = s_q.r2On;
   assign railOneDischarge = s_q.r1Dis;
   assign railTwoDischarge = s_q.r2Dis;
   assign goodFlagOut      = 1'b0;
   assign goodFlagOe       = s_q.pgLow;
   assign resetOut         = 1'b0;
   assign resetOe          = s_q.rstLow;
   assign hrdata           = s_q.rdata;
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign irq              = s_q.irq;

   AST_OFF_WHEN_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
      enN |=> !railOneOn && !railTwoOn) else $error("rail on while disabled");
   AST_LOCKOUT: assert property (@(posedge clk) disable iff (!rst_n)
      !supOk |=> !railOneOn && !railTwoOn) else $error("rail on in lockout");
   AST_ORDER_TWO_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(railOneOn) && $past(ordSel) && $past(ordSel, 2) |-> railTwoOn)
      else $error("rail one before rail two");
   AST_DROP_83: assert property (@(posedge clk) disable iff (!rst_n)
      ordSel && !r2At83 && !s_q.ctrl[0] |=> !railOneOn)
      else $error("rail one kept on below 83");
   AST_ONE_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.seq == drs_pkg::ST_OFF && !enN && supOk && !ordSel && !s_q.ctrl[0]
      |=> railOneOn && !railTwoOn) else $error("rail one not first");
   AST_GOOD_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 goodFlagOe == !$past(r1At95)) else $error("good flag wrong");
   AST_MANUAL_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      (!mrA || !mrB) |=> resetOe) else $error("manual reset ignored");
   AST_RAIL2_RESET: assert property (@(posedge clk) disable iff (!rst_n)
      !r2At95 |=> resetOe[*2]) else $error("reset not held on low rail");
   AST_RELEASE_DELAY: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(resetOe) |-> s_q.cnt == CW'(DELAY_CYC - 1))
      else $error("reset released early");
   AST_DISCHARGE: assert property (@(posedge clk) disable iff (!rst_n)
      railOneDischarge != railOneOn && railTwoDischarge != railTwoOn)
      else $error("discharge mismatch");
   // Leaving shutdown turns exactly the first rail of the order on
   AST_ENABLE_START: assert property (@(posedge clk) disable iff (!rst_n)
      s_q.seq == drs_pkg::ST_OFF && !enN && supOk && !s_q.ctrl[0]
      |=> railOneOn != railTwoOn) else $error("no rail started on enable");
   AST_GOOD_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
      r1At95 |=> !goodFlagOe) else $error("good flag not released");
   // The release delay may not be cut short while no cause is present
   AST_RESET_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      resetOe && s_q.cnt != CW'(DELAY_CYC - 1) |=> resetOe)
      else $error("reset released before count end");
   AST_ONE_FIRST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !ordSel && railOneOn && !enN && supOk && !s_q.ctrl[0] |=> railOneOn)
      else $error("rail one dropped in rail one first order");
   AST_SEQ_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n)
      $onehot(s_q.seq)) else $error("sequencer state not one-hot");
endmodule : drs_supervisor
`default_nettype wire

// [drs_cpu_model.sv]
/*
 Processor-side partner: resolves the open-drain reset and good lines with
 their pull-ups and can route the good line into a manual reset input.
 Assumes an output enable high means the supervisor pulls the pin low.
*/
`default_nettype none
module drs_cpu_model (
   // Open-drain enables
   input  wire logic goodFlagOe,
   input  wire logic resetOe,
   // Tracking option
   input  wire logic tieGood,
   // Resolved lines
   output logic      resetLine,
   output logic      goodLine,
   output logic      trackMr_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pins float up to the pull-up level
   assign resetLine = resetOe ? 1'b0 : 1'b1;
   assign goodLine  = goodFlagOe ? 1'b0 : 1'b1;
   assign trackMr_n = tieGood ? goodLine : 1'b1;
endmodule : drs_cpu_model
`default_nettype wire

// [dual_rail_sequence_supervisor_tb.sv]
/*
 Self-checking bench for drs_supervisor: rail level models, AHB-Lite master.
 Assumes zero wait states and the short release delay set below.
*/
`default_nettype none
module dual_rail_sequence_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY = 20;
   logic        clk, rst_n, enN, ordSel, mrA, mrB, supOk, ovl1, ovl2, tieGood;
   logic        hsel, hwrite, rdyPre, r1On, r2On, r1Dis, r2Dis, gOut, gOe;
   logic        rOut, rOe, hrdyOut, hresp, irq, rstLine, goodLine, trackMr_n;
   logic [1:0]  htrans;
   logic [5:0]  m;
   logic [31:0] haddr, hwdata, hrdata, rdPre, v;
   int          lvl1, lvl2, n_fail, num_checks, seed, cnt;

   drs_supervisor #(.DELAY_CYC(DLY)) dut (.clk(clk), .rst_n(rst_n), .enableIn_n(enN),
      .orderSelect(ordSel), .manualResetA_n(mrA & trackMr_n), .manualResetB_n(mrB),
      .supplyOneOk(supOk), .railTwoAbove83(lvl2 >= 83 && !ovl2),
      .railOneAbove95(lvl1 >= 95 && !ovl1), .railTwoAbove95(lvl2 >= 95 && !ovl2),
      .railOneOn(r1On), .railTwoOn(r2On), .railOneDischarge(r1Dis),
      .railTwoDischarge(r2Dis), .goodFlagOut(gOut), .goodFlagOe(gOe), .resetOut(rOut),
      .resetOe(rOe), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hrdyOut), .hrdata(hrdata),
      .hreadyout(hrdyOut), .hresp(hresp), .irq(irq));
   drs_cpu_model cpu (.goodFlagOe(gOe), .resetOe(rOe), .tieGood(tieGood),
      .resetLine(rstLine), .goodLine(goodLine), .trackMr_n(trackMr_n));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Rail levels in percent, ramping while the regulator is on
   always @(posedge clk) begin
      if (!rst_n) begin
         lvl1 <= 0;
         lvl2 <= 0;
      end else begin
         lvl1 <= r1On ? ((lvl1 > 90) ? 100 : lvl1 + 10) : 0;
         lvl2 <= r2On ? ((lvl2 > 90) ? 100 : lvl2 + 10) : 0;
      end
   end
   always @(negedge clk) begin
      rdPre = hrdata;
      rdyPre = hrdyOut;
   end

   function automatic logic expIrq(input logic [5:0] msk);
      expIrq = |(msk & 6'h0C);
   endfunction : expIrq
   function automatic logic pick(input int s);
      case (s)
         0: pick = r1On;
         1: pick = r2On;
         2: pick = gOe;
         default: pick = rOe;
      endcase
   endfunction : pick
   task end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk
   task waitFor(input int s, input logic val, input int lim);
      cnt = 0;
      do begin
         @(negedge clk);
         cnt++;
      end while (pick(s) !== val && cnt < lim);
      if (pick(s) !== val) begin
         n_fail++;
         end_of_test();
      end
   endtask : waitFor
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rdyPre !== 1'b1 && k < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin
         @(posedge clk);
         k++;
      end while (rdyPre !== 1'b1 && k < 100);
      v = rdPre;
      if (k >= 100) begin
         n_fail++;
         end_of_test();
      end
   endtask : bus
   task rdChk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(v, exp);
   endtask : rdChk

   initial begin
      seed = 58686;
      n_fail = 0;
      num_checks = 0;
      {rst_n, enN, ordSel, mrA, mrB, supOk, ovl1, ovl2, tieGood} = 9'h0F8;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(32'({r1On, r2On, r1Dis, r2Dis, gOe, rOe, irq}), 32'h1E);
      chk(32'({gOut, rOut, hresp, hrdyOut}), 32'h1);
      rdChk(8'h00, 32'h0);
      rdChk(8'h0C, 32'h0);
      rdChk(8'h10, 32'h0);
      supOk <= 1'b1;
      repeat (8) @(negedge clk);
      chk(32'(r1On | r2On), 32'h0);
      @(posedge clk);
      supOk <= 1'b0;
      enN <= 1'b0;
      repeat (8) @(negedge clk);
      chk(32'(r1On | r2On), 32'h0);
      @(posedge clk);
      supOk <= 1'b1;
      waitFor(1, 1'b1, 10);
      chk(32'(r1On), 32'h0);
      waitFor(0, 1'b1, 20);
      chk(32'(lvl2 >= 83), 32'h1);
      chk(32'({r1Dis, r2Dis}), 32'h0);
      waitFor(2, 1'b0, 20);
      chk(32'(goodLine), 32'h1);
      waitFor(3, 1'b0, DLY + 40);
      chk(32'(rstLine), 32'h1);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         if (i == 0) mrA <= 1'b0;
         else mrB <= 1'b0;
         waitFor(3, 1'b1, 6);
         chk(32'(rstLine), 32'h0);
         @(posedge clk);
         mrA <= 1'b1;
         mrB <= 1'b1;
         waitFor(3, 1'b0, DLY + 10);
         chk(32'(cnt >= DLY), 32'h1);
      end
      @(posedge clk);
      ovl2 <= 1'b1;
      waitFor(0, 1'b0, 6);
      waitFor(3, 1'b1, 6);
      chk(32'({r2On, rstLine}), 32'h2);
      @(posedge clk);
      ovl2 <= 1'b0;
      waitFor(0, 1'b1, 10);
      waitFor(3, 1'b0, DLY + 10);
      for (int i = 0; i < 3; i++) begin
         m = (i == 0) ? 6'h3F : 6'($random(seed));
         bus(1'b1, 8'h0C, {26'h0, m});
         bus(1'b1, 8'h08, 32'h3F);
         @(posedge clk);
         ovl1 <= 1'b1;
         waitFor(2, 1'b1, 6);
         chk(32'(goodLine), 32'h0);
         @(posedge clk);
         ovl1 <= 1'b0;
         waitFor(2, 1'b0, 6);
         repeat (2) @(negedge clk);
         chk(32'(irq), 32'(expIrq(m)));
         rdChk(8'h08, 32'h0C);
         bus(1'b1, 8'h08, 32'h0C);
         rdChk(8'h08, 32'h0);
         chk(32'(irq), 32'h0);
      end
      @(posedge clk);
      tieGood <= 1'b1;
      ovl1 <= 1'b1;
      waitFor(3, 1'b1, 10);
      chk(32'(rstLine), 32'h0);
      @(posedge clk);
      ovl1 <= 1'b0;
      tieGood <= 1'b0;
      waitFor(3, 1'b0, DLY + 20);
      bus(1'b1, 8'h00, 32'h2);
      waitFor(3, 1'b1, 6);
      rdChk(8'h00, 32'h2);
      bus(1'b1, 8'h00, 32'h0);
      enN <= 1'b1;
      waitFor(1, 1'b0, 6);
      chk(32'({r1On, r1Dis, r2Dis}), 32'h3);
      @(posedge clk);
      ordSel <= 1'b0;
      enN <= 1'b0;
      waitFor(0, 1'b1, 10);
      chk(32'(r2On), 32'h0);
      waitFor(1, 1'b1, 10);
      // Reset in mid-run returns every output to its idle level
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(32'({r1On, r2On, r1Dis, r2Dis, gOe, rOe, irq}), 32'h1E);
      end_of_test();
   end
endmodule : dual_rail_sequence_supervisor_tb
`default_nettype wire
